// ---- rtl/dptm_top.sv ----
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module dptm_top (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // process inputs, same clock domain
    input  wire dptm_pkg::dptm_pid_in_t pidIn,
    input  wire logic        accelDecel,
    // pins
    input  wire logic        timerPin,
    input  wire logic        saveCmdPin,
    // outputs
    output logic             timerOutPin,
    output logic      [7:0]  displayLine1,
    output logic      [7:0]  displayLine2,
    output logic             bannerShown,
    output logic signed [15:0] commandFreq,
    output logic      [7:0]  voltageScale
);
    // configuration registers
    dptm_pkg::dptm_monitor_t monitor;
    logic [15:0] onDelay, offDelay;
    logic [4:0]  multiInFunc, multiOutFunc;
    logic [7:0]  feedbackGain, propGain;
    logic [15:0] integralTime, derivTime, integralLimit;
    logic [3:0]  pidMode, pidEnable;
    logic [7:0]  saveGain;
    logic [1:0]  freqSource;
    logic        showStartup;

    // pin synchronisers
    logic timerMeta, timerSync, saveMeta, saveSync;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timerMeta <= 1'b0;
            timerSync <= 1'b0;
            saveMeta  <= 1'b0;
            saveSync  <= 1'b0;
        end else begin
            timerMeta <= timerPin;
            timerSync <= timerMeta;
            saveMeta  <= saveCmdPin;
            saveSync  <= saveMeta;
        end
    end

    // tick generators
    logic [22:0] tickCnt;
    logic [17:0] baseCnt;
    wire  logic  tick100 = tickCnt == 23'(dptm_pkg::TICK_CYCLES - 1);
    wire  logic  tickBase = baseCnt == 18'(dptm_pkg::PID_BASE_CYCLES - 1);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tickCnt <= 23'h00_0000;
            baseCnt <= 18'h0_0000;
        end else begin
            tickCnt <= tick100 ? 23'h00_0000 : tickCnt + 23'h00_0001;
            baseCnt <= tickBase ? 18'h0_0000 : baseCnt + 18'h0_0001;
        end
    end

    // delay timer
    wire logic timerEnable = multiInFunc == dptm_pkg::TIMER_IN_FUNC
                          && multiOutFunc == dptm_pkg::TIMER_OUT_FUNC;
    logic timerOut;
    dptm_delay_timer u_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .enable   (timerEnable),
        .onDelay  (onDelay),
        .offDelay (offDelay),
        .tick     (tick100),
        .timerIn  (timerSync),
        .timerOut (timerOut)
    );

    // pid datapath; gains in percent, times in 0.1 s and ms
    wire logic pidOn = pidEnable == dptm_pkg::PID_ENABLE_CODE
                    && pidMode != 4'h0 && pidMode <= dptm_pkg::PID_MODE_MAX;
    wire logic negative = pidMode > 4'h4;
    wire logic oddMode  = pidMode[0];
    wire logic addRef   = pidMode == 4'h3 || pidMode == 4'h4
                       || pidMode == 4'h7 || pidMode == 4'h8;
    // widen before the product so a full-scale feedback times 100 percent does not wrap
    wire logic signed [31:0] fbScaled = 32'(pidIn.feedback) * $signed({24'h00_0000, feedbackGain}) / 32'sd100;
    wire logic signed [31:0] devRaw   = 32'(pidIn.target) - fbScaled;
    wire logic signed [31:0] deviation = negative ? -devRaw : devRaw;
    wire logic signed [31:0] pTerm = 32'(deviation * $signed({1'b0, propGain})) / 32'sd100;
    wire logic signed [31:0] dInput = oddMode ? fbScaled - 32'(pidIn.freqRef) : fbScaled;
    wire logic signed [31:0] limit = $signed({16'h0000, integralLimit});
    // integral step per 100 ms tick: deviation / integralTime, so the sum reaches deviation after integralTime
    wire logic signed [31:0] iStep = integralTime == 16'h0000 ? 32'sd0
                                   : deviation / $signed({16'h0000, integralTime});
    logic signed [31:0] integral, lastDIn, dTerm;
    wire logic signed [31:0] iSum = integral + iStep;
    wire logic signed [31:0] iClamped = iSum > limit ? limit : (iSum < -limit ? -limit : iSum);
    wire logic bothZero = pidIn.target == 16'sh0000 && pidIn.feedback == 16'sh0000;
    wire logic signed [31:0] pidSum = pTerm + integral + dTerm + (addRef ? 32'(pidIn.freqRef) : 32'sd0);
    wire logic signed [15:0] next_commandFreq = !pidOn ? pidIn.freqRef
                                              : bothZero ? 16'sh0000
                                              : pidSum > 32'sd32767 ? 16'sh7FFF
                                              : pidSum < -32'sd32768 ? 16'sh8000 : pidSum[15:0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            integral <= 32'sh0000_0000;
            lastDIn  <= 32'sh0000_0000;
            dTerm    <= 32'sh0000_0000;
        end else if (!pidOn) begin
            integral <= 32'sh0000_0000;
            lastDIn  <= dInput;
            dTerm    <= 32'sh0000_0000;
        end else begin
            if (tick100)
                integral <= iClamped;
            if (tickBase) begin
                lastDIn <= dInput;
                dTerm   <= 32'((dInput - lastDIn) * $signed({16'h0000, derivTime})) / 32'sd5;
            end
        end
    end

    // energy saving
    wire logic saveEnabled = saveGain != dptm_pkg::SAVE_UNITY;
    wire logic saveActive = saveEnabled && saveSync && !pidOn && !accelDecel;
    wire logic [7:0] next_voltageScale = saveActive ? saveGain : dptm_pkg::SAVE_UNITY;

    // display selection
    wire logic startupBanner = monitor.powerOn == dptm_pkg::MON_BANNER;
    wire logic [7:0] next_line1 = showStartup && startupBanner ? dptm_pkg::MON_FREQ_CMD
                                : dptm_pkg::dptm_mon_clip(monitor.line1);
    wire logic [7:0] next_line2 = showStartup ? (startupBanner ? dptm_pkg::MON_BANNER
                                                : dptm_pkg::dptm_mon_clip(monitor.powerOn))
                                : dptm_pkg::dptm_mon_clip(monitor.line2);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timerOutPin  <= 1'b0;
            displayLine1 <= dptm_pkg::MON_FREQ_CMD;
            displayLine2 <= dptm_pkg::MON_BANNER;
            bannerShown  <= 1'b1;
            commandFreq  <= 16'sh0000;
            voltageScale <= dptm_pkg::SAVE_UNITY;
        end else begin
            timerOutPin  <= timerOut;
            displayLine1 <= next_line1;
            displayLine2 <= next_line2;
            bannerShown  <= showStartup && startupBanner;
            commandFreq  <= next_commandFreq;
            voltageScale <= next_voltageScale;
        end
    end

    // wishbone slave: one wait state, ack one cycle
    wire logic req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wrReq = req && wb_we_i;
    wire logic hitMon  = wb_adr_i == dptm_pkg::REG_MONITOR;
    wire logic hitTim  = wb_adr_i == dptm_pkg::REG_TIMER;
    wire logic hitGain = wb_adr_i == dptm_pkg::REG_PID_GAIN;
    wire logic hitTime = wb_adr_i == dptm_pkg::REG_PID_TIME;
    wire logic hitCtrl = wb_adr_i == dptm_pkg::REG_PID_CTRL;
    wire logic hitSave = wb_adr_i == dptm_pkg::REG_SAVE;
    wire logic [31:0] mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    logic [31:0] rdData;
    always_comb begin
        if (hitMon)
            rdData = {8'h00, monitor};
        else if (hitTim)
            rdData = {offDelay, onDelay};
        else if (hitGain)
            rdData = {integralLimit, propGain, feedbackGain};
        else if (hitTime)
            rdData = {derivTime, integralTime};
        else if (hitCtrl)
            rdData = {5'h00, freqSource, 4'h0, multiOutFunc, 3'h0, multiInFunc, pidEnable, pidMode};
        else if (hitSave)
            rdData = {24'h00_0000, saveGain};
        else if (wb_adr_i == dptm_pkg::REG_STATUS)
            rdData = {24'h00_0000, timerEnable, saveActive, pidOn, timerOut, 4'h0};
        else if (wb_adr_i == dptm_pkg::REG_PID_OUT)
            rdData = {integral[15:0], commandFreq};
        else
            rdData = 32'h0000_0000;
    end
    wire logic [31:0] wrMon  = (rdData & ~mask) | (wb_dat_i & mask);
    wire logic [7:0]  wrGain = wrMon[7:0];
    // save gains outside 50..150 are refused and the old value kept
    wire logic gainOk = wrGain >= dptm_pkg::SAVE_MIN && wrGain <= dptm_pkg::SAVE_MAX;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h0000_0000;
            monitor       <= '{line1: dptm_pkg::MON_FREQ_CMD, line2: dptm_pkg::MON_FREQ_CMD,
                               powerOn: dptm_pkg::MON_BANNER};
            onDelay       <= 16'h0000;
            offDelay      <= 16'h0000;
            feedbackGain  <= 8'h64;
            propGain      <= 8'h64;
            integralLimit <= 16'h0064;
            integralTime  <= 16'h000A;
            derivTime     <= 16'h0000;
            pidMode       <= 4'h0;
            pidEnable     <= 4'h0;
            multiInFunc   <= 5'h00;
            multiOutFunc  <= 5'h00;
            freqSource    <= 2'h0;
            saveGain      <= dptm_pkg::SAVE_UNITY;
            showStartup   <= 1'b1;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rdData : 32'h0000_0000;
            // startup view ends once a display line byte is written; the power-on byte alone keeps it
            if (wrReq && hitMon) begin
                monitor <= wrMon[23:0];
                if (wb_sel_i[2:1] != 2'h0)
                    showStartup <= 1'b0;
            end
            if (wrReq && hitTim) begin
                onDelay  <= wrMon[15:0];
                offDelay <= wrMon[31:16];
            end
            if (wrReq && hitGain) begin
                feedbackGain  <= wrMon[7:0];
                propGain      <= wrMon[15:8];
                integralLimit <= wrMon[31:16];
            end
            if (wrReq && hitTime) begin
                integralTime <= wrMon[15:0];
                derivTime    <= wrMon[31:16];
            end
            if (wrReq && hitCtrl) begin
                pidMode      <= wrMon[3:0];
                pidEnable    <= wrMon[7:4];
                multiInFunc  <= wrMon[12:8];
                multiOutFunc <= wrMon[20:16];
                freqSource   <= wrMon[17 + 8 +: 2];
            end
            if (wrReq && hitSave && gainOk)
                saveGain <= wrGain;
        end
    end
endmodule

// ---- rtl/dptm_pkg.sv ----
// Function
// - display lines pick one of eighteen monitor items, codes 01 to 18
// - power-on select 00 shows frequency command and a fixed banner
// - nonzero power-on select shows line1 item and power-on line2 item
// - timer active only with input function 19 and output function 21
// - timer output turns on after input stays on longer than on delay
// - timer output turns off after input stays off longer than off delay
// - deviation is target minus feedback times feedback gain
// - proportional term is deviation times proportional gain
// - integral reaches the deviation after integral time for constant deviation
// - integral magnitude is clamped to the integral limit
// - derivative is input change times derivative time over 5 ms
// - PID runs only when enable select equals 1
// - zero target and zero feedback force zero output frequency; the code does so only while PID runs, otherwise it passes freqRef through
// - modes 0-8: 0 off, 1-4 positive, 5-8 negative, odd/even derivative input
// - modes 3,4,7,8 add frequency reference to PID output
// - energy saving disabled at gain 100 percent, enabled otherwise
// - saving command scales voltage by gain, gain accepted 50 to 150 percent
// - no energy saving during PID control or ramping
package dptm_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned TICK_MS         = 100;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned PID_BASE_MS     = 5;
    localparam int unsigned PID_BASE_CYCLES = CLK_HZ / 1000 * PID_BASE_MS;
    localparam logic [7:0]  MON_MIN         = 8'h01;
    localparam logic [7:0]  MON_MAX         = 8'h12;
    localparam logic [7:0]  MON_BANNER      = 8'h00;
    localparam logic [7:0]  MON_FREQ_CMD    = 8'h01;
    localparam logic [4:0]  TIMER_IN_FUNC   = 5'h13;
    localparam logic [4:0]  TIMER_OUT_FUNC  = 5'h15;
    localparam logic [7:0]  SAVE_UNITY      = 8'h64;
    localparam logic [7:0]  SAVE_MIN        = 8'h32;
    localparam logic [7:0]  SAVE_MAX        = 8'h96;
    localparam logic [3:0]  PID_MODE_MAX    = 4'h8;
    localparam logic [3:0]  PID_ENABLE_CODE = 4'h1;
    localparam logic [1:0]  FREQ_SRC_PULSE  = 2'h3;
    // wishbone register byte offsets
    localparam logic [5:0]  REG_MONITOR     = 6'h00;
    localparam logic [5:0]  REG_TIMER       = 6'h04;
    localparam logic [5:0]  REG_PID_GAIN    = 6'h08;
    localparam logic [5:0]  REG_PID_TIME    = 6'h0C;
    localparam logic [5:0]  REG_PID_CTRL    = 6'h10;
    localparam logic [5:0]  REG_SAVE        = 6'h14;
    localparam logic [5:0]  REG_STATUS      = 6'h18;
    localparam logic [5:0]  REG_PID_OUT     = 6'h1C;

    typedef struct packed {
        logic [7:0] line1;
        logic [7:0] line2;
        logic [7:0] powerOn;
    } dptm_monitor_t;

    typedef struct packed {
        logic signed [15:0] target;
        logic signed [15:0] feedback;
        logic signed [15:0] freqRef;
    } dptm_pid_in_t;

    function automatic logic [7:0] dptm_mon_clip(input logic [7:0] code);
        dptm_mon_clip = (code < MON_MIN || code > MON_MAX) ? MON_MIN : code;
    endfunction
endpackage

// ---- rtl/dptm_delay_timer.sv ----
`timescale 1ns/10ps
module dptm_delay_timer (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // control
    input  wire logic        enable,
    input  wire logic [15:0] onDelay,
    input  wire logic [15:0] offDelay,
    input  wire logic        tick,
    input  wire logic        timerIn,
    // result
    output logic             timerOut
);
    logic        lastIn;
    logic [15:0] elapsed;
    wire  logic  changed = timerIn != lastIn;
    wire  logic  onDone  = elapsed > onDelay;
    wire  logic  offDone = elapsed > offDelay;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lastIn   <= 1'b0;
            elapsed  <= 16'h0000;
            timerOut <= 1'b0;
        end else if (!enable) begin
            lastIn   <= timerIn;
            elapsed  <= 16'h0000;
            timerOut <= 1'b0;
        end else begin
            lastIn <= timerIn;
            if (changed)
                elapsed <= 16'h0000;
            else if (tick && elapsed != 16'hFFFF)
                elapsed <= elapsed + 16'h0001;
            if (timerIn && !changed && onDone)
                timerOut <= 1'b1;
            else if (!timerIn && !changed && offDone)
                timerOut <= 1'b0;
        end
    end
endmodule

// ---- tb/dptm_props.sv ----
`timescale 1ns/10ps
module dptm_props (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // wishbone
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic [31:0]            wb_dat_o,
    input  wire logic                   wb_ack_o,
    // process side
    input  wire dptm_pkg::dptm_pid_in_t pidIn,
    input  wire logic                   accelDecel,
    input  wire logic                   timerPin,
    input  wire logic                   saveCmdPin,
    input  wire logic                   timerOutPin,
    input  wire logic [7:0]             displayLine1,
    input  wire logic [7:0]             displayLine2,
    input  wire logic                   bannerShown,
    input  wire logic signed [15:0]     commandFreq,
    input  wire logic [7:0]             voltageScale
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_line1_range; displayLine1 >= dptm_pkg::MON_MIN && displayLine1 <= dptm_pkg::MON_MAX; endproperty
    a_line1_range: assert property (p_line1_range) else $error("line1 code out of range");
    property p_banner; bannerShown |-> displayLine2 == dptm_pkg::MON_BANNER && displayLine1 == dptm_pkg::MON_FREQ_CMD;
    endproperty
    a_banner: assert property (p_banner) else $error("banner view wrong");
    property p_scale_range; voltageScale >= dptm_pkg::SAVE_MIN && voltageScale <= dptm_pkg::SAVE_MAX; endproperty
    a_scale_range: assert property (p_scale_range) else $error("voltage scale out of range");
    property p_ramp_nosave; accelDecel [*4] |-> voltageScale == dptm_pkg::SAVE_UNITY; endproperty
    a_ramp_nosave: assert property (p_ramp_nosave) else $error("saving while ramping");
    property p_cmd_off; !saveCmdPin [*4] |-> voltageScale == dptm_pkg::SAVE_UNITY; endproperty
    a_cmd_off: assert property (p_cmd_off) else $error("saving without command");
    // freqRef included since a disabled loop passes the reference through
    property p_zero; (pidIn == '0) [*8] |-> commandFreq == 16'sh0000; endproperty
    a_zero: assert property (p_zero) else $error("zero inputs give nonzero frequency");
    property p_timer_rise; $rose(timerOutPin) |-> $past(timerPin, 4); endproperty
    a_timer_rise: assert property (p_timer_rise) else $error("timer output rose without input");
endmodule

// ---- tb/dptm_partner.sv ----
`timescale 1ns/10ps
module dptm_partner (
    // clock
    input  wire logic ref_clk,
    // levels wanted by the bench
    input  wire logic timerWant,
    input  wire logic saveWant,
    // terminal pins
    output logic      timerPin,
    output logic      saveCmdPin
);
    // contacts move just after the edge, never mid-cycle
    initial begin
        timerPin = 1'b0;
        saveCmdPin = 1'b0;
    end
    always @(posedge ref_clk) begin
        timerPin   <= timerWant;
        saveCmdPin <= saveWant;
    end
endmodule

// ---- tb/dptm_top_tb.sv ----
`timescale 1ns/10ps
module dptm_top_tb;
    logic ref_clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, accelDecel = 1'b0;
    logic timerWant = 1'b0, saveWant = 1'b0;
    logic [5:0] wbAdr = '0;
    logic [3:0] wbSel = '0;
    logic [3:0] selW = 4'hF;
    logic [31:0] wbDatI = '0;
    dptm_pkg::dptm_pid_in_t pidIn = '0;
    wire logic [31:0] wbDatO;
    wire logic wbAck, timerPin, saveCmdPin, timerOutPin, bannerShown;
    wire logic [7:0] displayLine1, displayLine2, voltageScale;
    wire logic signed [15:0] commandFreq;
    int errorCnt = 0, testsRun = 0, seed = 32'h5596;
    logic [31:0] rdQ[$];
    always #10 ref_clk = ~ref_clk;
    dptm_partner partner_u (.ref_clk(ref_clk), .timerWant(timerWant), .saveWant(saveWant),
        .timerPin(timerPin), .saveCmdPin(saveCmdPin));
    dptm_top dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .pidIn(pidIn), .accelDecel(accelDecel), .timerPin(timerPin), .saveCmdPin(saveCmdPin),
        .timerOutPin(timerOutPin), .displayLine1(displayLine1), .displayLine2(displayLine2),
        .bannerShown(bannerShown), .commandFreq(commandFreq), .voltageScale(voltageScale));
    task automatic results;
        $display("Checks %0d errors %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [5:0] adr, input logic [31:0] dat);
        int n;
        {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'h3, we, adr, selW, dat};
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (wbAck === 1'b1) break;
        end
        if (n == 20) begin
            errorCnt++;
            results();
        end
        {wbCyc, wbStb} <= 2'h0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [5:0] adr, input logic [31:0] exp);
        rdQ.push_back(exp);
        wb(1'b0, adr, 32'h0000_0000);
    endtask
    // read data stands only in the ack cycle, so it is taken at that edge
    always @(posedge ref_clk) begin
        if (wbAck === 1'b1 && wbWe === 1'b0) begin
            if (rdQ.size() == 0) chk("unexpected read", 32'h0000_0000, 32'hFFFF_FFFF);
            else chk("read data", rdQ.pop_front(), wbDatO);
        end
    end
    function automatic logic [31:0] get(input int sel);
        case (sel)
            0: get = {24'h00_0000, displayLine1};
            1: get = {24'h00_0000, displayLine2};
            2: get = {31'h0000_0000, bannerShown};
            3: get = {24'h00_0000, voltageScale};
            default: get = {{16{commandFreq[15]}}, commandFreq};
        endcase
    endfunction
    // output latency is not fixed, so wait for the value under a bound
    task automatic waitOut(input int sel, input logic [31:0] exp, input string name);
        for (int n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            #1;
            if (get(sel) === exp) break;
        end
        chk(name, exp, get(sel));
        @(posedge ref_clk);
    endtask
    function automatic logic [31:0] ctrl(input int m, input logic [3:0] en, input logic [4:0] inF);
        ctrl = {5'h00, dptm_pkg::FREQ_SRC_PULSE, 4'h0, dptm_pkg::TIMER_OUT_FUNC, 3'h0, inF, en, 4'(m)};
    endfunction
    logic [7:0] gw[4] = '{8'h28, 8'h97, 8'h96, 8'h32};
    logic [7:0] ge[4] = '{8'h64, 8'h64, 8'h96, 8'h32};
    initial begin
        int t, f, g;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        waitOut(0, 32'h0000_0001, "line1 at power-on");
        waitOut(1, 32'h0000_0000, "line2 at power-on");
        waitOut(2, 32'h0000_0001, "banner at power-on");
        waitOut(3, 32'h0000_0064, "volt scale at reset");
        selW = 4'h1;
        wb(1'b1, dptm_pkg::REG_MONITOR, 32'h0000_0002);
        selW = 4'hF;
        rd(dptm_pkg::REG_MONITOR, 32'h0001_0102);
        waitOut(1, 32'h0000_0002, "line2 power-on item");
        waitOut(0, 32'h0000_0001, "line1 power-on item");
        waitOut(2, 32'h0000_0000, "banner off for item");
        wb(1'b1, dptm_pkg::REG_MONITOR, 32'h0003_0705);
        rd(dptm_pkg::REG_MONITOR, 32'h0003_0705);
        waitOut(0, 32'h0000_0003, "line1 item");
        waitOut(1, 32'h0000_0007, "line2 item");
        waitOut(2, 32'h0000_0000, "banner gone");
        wb(1'b1, 6'h20, 32'hFFFF_FFFF);
        rd(6'h20, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, dptm_pkg::REG_SAVE, {24'h00_0000, gw[i]});
            rd(dptm_pkg::REG_SAVE, {24'h00_0000, ge[i]});
        end
        saveWant <= 1'b1;
        waitOut(3, 32'h0000_0032, "volt scale saving");
        accelDecel <= 1'b1;
        waitOut(3, 32'h0000_0064, "volt scale ramping");
        accelDecel <= 1'b0;
        wb(1'b1, dptm_pkg::REG_SAVE, 32'h0000_0064);
        waitOut(3, 32'h0000_0064, "volt scale unity");
        saveWant <= 1'b0;
        rd(dptm_pkg::REG_PID_GAIN, 32'h0064_6464);
        wb(1'b1, dptm_pkg::REG_PID_TIME, 32'h0000_000A);
        wb(1'b1, dptm_pkg::REG_PID_CTRL, ctrl(2, 4'h1, 5'h12));
        rd(dptm_pkg::REG_STATUS, 32'h0000_0020);
        wb(1'b1, dptm_pkg::REG_PID_CTRL, ctrl(2, 4'h2, dptm_pkg::TIMER_IN_FUNC));
        rd(dptm_pkg::REG_STATUS, 32'h0000_0080);
        pidIn <= {16'h00C8, 16'h0032, 16'h03E8};
        for (int m = 0; m < 9; m++) begin
            wb(1'b1, dptm_pkg::REG_PID_CTRL, ctrl(m, 4'h1, dptm_pkg::TIMER_IN_FUNC));
            rd(dptm_pkg::REG_STATUS, {24'h00_0000, 2'h2, m != 0, 5'h00});
            if (m != 0) waitOut(4, 32'(((m > 4) ? -150 : 150) + ((m % 4 < 1 || m % 4 == 3) ? 1000 : 0)),
                "pid mode freq");
        end
        saveWant <= 1'b1;
        wb(1'b1, dptm_pkg::REG_SAVE, 32'h0000_0032);
        repeat (8) @(posedge ref_clk);
        waitOut(3, 32'h0000_0064, "volt scale under pid");
        saveWant <= 1'b0;
        wb(1'b1, dptm_pkg::REG_PID_CTRL, ctrl(2, 4'h1, dptm_pkg::TIMER_IN_FUNC));
        rd(dptm_pkg::REG_PID_CTRL, ctrl(2, 4'h1, dptm_pkg::TIMER_IN_FUNC));
        g = 100;
        for (int i = 0; i < 6; i++) begin
            if (i == 3) begin
                g = 50;
                wb(1'b1, dptm_pkg::REG_PID_GAIN, 32'h0064_6432);
            end
            t = $unsigned($random(seed)) % 1000;
            f = 2 * ($unsigned($random(seed)) % 500);
            pidIn <= {16'(t), 16'(f), 16'h03E8};
            waitOut(4, 32'(t - f * g / 100), "deviation");
        end
        wb(1'b1, dptm_pkg::REG_PID_GAIN, 32'h0064_C864);
        pidIn <= {16'h00C8, 16'h0032, 16'h03E8};
        waitOut(4, 32'h0000_012C, "proportional");
        wb(1'b1, dptm_pkg::REG_PID_CTRL, ctrl(3, 4'h1, dptm_pkg::TIMER_IN_FUNC));
        pidIn <= '0;
        waitOut(4, 32'h0000_0000, "zero inputs");
        results();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        errorCnt++;
        results();
    end
endmodule
bind dptm_top dptm_props props_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pidIn(pidIn), .accelDecel(accelDecel), .timerPin(timerPin),
    .saveCmdPin(saveCmdPin), .timerOutPin(timerOutPin), .displayLine1(displayLine1),
    .displayLine2(displayLine2), .bannerShown(bannerShown), .commandFreq(commandFreq),
    .voltageScale(voltageScale));
